//--- src/etu_defines.svh
`ifndef ETU_DEFINES_SVH
`define ETU_DEFINES_SVH

// Register byte offsets
`define ETU_OFF_TCTRL 8'h00
`define ETU_OFF_TMR0 8'h04
`define ETU_OFF_REL0 8'h08
`define ETU_TMR_STEP 8'h08
`define ETU_OFF_STAT 8'h14
`define ETU_OFF_MASK 8'h18
`define ETU_OFF_PINS 8'h1c
`define ETU_OFF_CCV 8'h40
`define ETU_OFF_CCC 8'h80
`define ETU_OFF_END 8'hc0
`define ETU_WORD 8'h04

// Field layout
`define ETU_TC_POS 8
`define ETU_CFG_W 6
`define ETU_STAG_BIT 16
`define ETU_STAG_PH 3'h7

// Values
`define ETU_TMR_MAX 16'hffff
`define ETU_TMR_RST 16'h0000
`define ETU_TMR_INC 16'h0001
`define ETU_PRE_INC 8'h01
`define ETU_RESP_OK 2'h0
`define ETU_RESP_ERR 2'h2

`endif

//--- src/etu_pkg.sv
package etu_pkg;

  typedef enum logic [2:0] {
    ETU_OFF, ETU_CAP_RISE, ETU_CAP_FALL, ETU_CAP_BOTH,
    ETU_CMP0, ETU_CMP1, ETU_CMP2, ETU_CMP3
  } etu_mode_e;

  typedef enum logic [1:0] {ETU_SRC_PRE, ETU_SRC_SIX, ETU_SRC_EXT} etu_src_e;

  typedef struct packed {
    logic single;
    logic dbl;
    logic tsel;
    etu_mode_e mode;
  } etu_chcfg_s;

  typedef struct packed {
    etu_src_e src;
    logic [2:0] psel;
    logic run;
  } etu_tcfg_s;

endpackage : etu_pkg

//--- src/etu_event_timing_unit.sv
// What this block does
// R1: Sixteen channels; one-cycle resolution, eight cycles when staggered.
// R2: Two independent 16-bit timers, each reloading from its own register.
// R3: Timer clock is a selectable prescaled tick or timer-six overflow.
// R4: Timer may instead count edges on an external count input.
// R5: Each channel picks its timer and capture or compare function.
// R6: Each channel owns one pin: capture input or compare output.
// R7: Capture latches assigned timer on pin event and requests interrupt.
// R8: Capture edge selectable: rising, falling or both.
// R9: Compare channels match their timer continuously and act by mode.
// R10: Mode 0 interrupts only, pin untouched, many matches per period.
// R11: Mode 1 toggles pin on every match, many per period.
// R12: Mode 2 interrupts only, at most once per timer period.
// R13: Mode 3 sets pin on match, clears on overflow, once per period.
// R14: Double register: two channels toggle one shared pin on matches.
// R15: Single event with any compare mode gives one edge or pulse; the channel turns off at its first match, so mode 3 never clears its pin.
// R16: After reset all channels are off: no capture, compare or pin change.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`include "etu_defines.svh"

module etu_event_timing_unit
  import etu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Channel pins
  input wire logic [15:0] pinIn,
  output logic [15:0] pinOut,
  output logic [15:0] pinOe_n,
  // Timer count sources
  input wire logic [1:0] extCount,
  input wire logic timerSixOvf,
  // Interrupt
  output logic irq
);

  function automatic logic isHit(input logic [7:0] a, input logic [7:0] off);
    isHit = (a == off);
  endfunction : isHit

  function automatic logic [7:0] preMask(input logic [2:0] sel);
    preMask = (`ETU_PRE_INC << sel) - `ETU_PRE_INC;
  endfunction : preMask

  // Bus write strobe
  wire logic wrEn = awready && awvalid && wready && wvalid;
  wire logic rdHs = arready && arvalid;
  wire logic [31:0] wMask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] o);
    merge = (o & ~wMask) | (wdata & wMask);
  endfunction : merge

  function automatic logic [15:0] merge16(input logic [15:0] o);
    merge16 = (o & ~wMask[15:0]) | (wdata[15:0] & wMask[15:0]);
  endfunction : merge16

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && ((a <= `ETU_OFF_PINS) ||
             ((a >= `ETU_OFF_CCV) && (a < `ETU_OFF_END)));
  endfunction : mapped

  // State
  etu_tcfg_s tcfg [2];
  logic stag;
  logic [15:0] timer [2];
  logic [15:0] reload [2];
  logic tChg [2];
  logic ovf [2];
  logic tick [2];
  etu_chcfg_s cfg [16];
  logic [15:0] ccVal [16];
  logic done [16];
  logic drv [16];
  logic pinQ [16];
  logic [15:0] stat;
  logic [15:0] mask;
  logic [7:0] preCnt;
  logic [15:0] pinM, pinS, pinP;
  logic [1:0] extM, extS, extP;
  logic [15:0] act, hit, capEv, wrCfg;

  // Input synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinM <= 16'h0000;
      pinS <= 16'h0000;
      pinP <= 16'h0000;
      extM <= 2'h0;
      extS <= 2'h0;
      extP <= 2'h0;
    end else begin
      pinM <= pinIn;
      pinS <= pinM;
      pinP <= pinS;
      extM <= extCount;
      extS <= extM;
      extP <= extS;
    end
  end

  wire logic [15:0] rise = pinS & ~pinP;
  wire logic [15:0] fall = ~pinS & pinP;
  wire logic [1:0] extRise = extS & ~extP;

  // Prescaler; staggered mode only ticks on the last phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt <= 8'h00;
    end else begin
      preCnt <= preCnt + `ETU_PRE_INC;
    end
  end

  wire logic stagOk = !stag || (preCnt[2:0] == `ETU_STAG_PH); // R1

  // Control word
  wire logic [31:0] tctrlWord = {15'h0000, stag, 2'h0, tcfg[1], 2'h0, tcfg[0]};
  wire logic wrTctrl = wrEn && isHit(awaddr, `ETU_OFF_TCTRL);
  wire logic [31:0] tctrlNew = merge(tctrlWord);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tcfg[0] <= '0;
      tcfg[1] <= '0;
      stag <= 1'b0;
    end else if (wrTctrl) begin
      tcfg[0] <= etu_tcfg_s'(tctrlNew[`ETU_CFG_W-1:0]);
      tcfg[1] <= etu_tcfg_s'(tctrlNew[`ETU_TC_POS +: `ETU_CFG_W]);
      stag <= tctrlNew[`ETU_STAG_BIT];
    end
  end

  // Time bases
  for (genvar t = 0; t < 2; t++) begin : g_tmr
    localparam logic [7:0] TOFF = `ETU_OFF_TMR0 + 8'(t) * `ETU_TMR_STEP;
    localparam logic [7:0] ROFF = `ETU_OFF_REL0 + 8'(t) * `ETU_TMR_STEP;
    wire logic wrTmr = wrEn && isHit(awaddr, TOFF);
    wire logic wrRel = wrEn && isHit(awaddr, ROFF);
    wire logic wrap = (timer[t] == `ETU_TMR_MAX);
    wire logic [7:0] pm = preMask(tcfg[t].psel);
    wire logic preTick = ((preCnt | ~pm) == 8'hff) && stagOk; // R1
    wire logic srcTick = (tcfg[t].src == ETU_SRC_PRE) ? preTick : // R3
                         (tcfg[t].src == ETU_SRC_SIX) ? timerSixOvf : // R3
                         (tcfg[t].src == ETU_SRC_EXT) ? extRise[t] : 1'b0; // R4
    assign tick[t] = tcfg[t].run && srcTick;

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        timer[t] <= `ETU_TMR_RST;
        reload[t] <= `ETU_TMR_RST;
        tChg[t] <= 1'b0;
        ovf[t] <= 1'b0;
      end else begin
        tChg[t] <= tick[t] || wrTmr;
        ovf[t] <= tick[t] && wrap;
        if (wrRel) begin
          reload[t] <= merge16(reload[t]);
        end
        if (wrTmr) begin
          timer[t] <= merge16(timer[t]);
        end else if (tick[t]) begin
          timer[t] <= wrap ? reload[t] : timer[t] + `ETU_TMR_INC; // R2
        end
      end
    end
  end

  // Channels
  for (genvar i = 0; i < 16; i++) begin : g_ch
    localparam logic [7:0] VOFF = `ETU_OFF_CCV + 8'(i) * `ETU_WORD;
    localparam logic [7:0] COFF = `ETU_OFF_CCC + 8'(i) * `ETU_WORD;
    wire logic wrVal = wrEn && isHit(awaddr, VOFF);
    assign wrCfg[i] = wrEn && isHit(awaddr, COFF);
    wire logic [15:0] cfgMrg = merge16({10'h000, cfg[i]});
    wire etu_chcfg_s cfgNew = etu_chcfg_s'(cfgMrg[`ETU_CFG_W-1:0]);
    wire etu_mode_e md = cfg[i].mode;
    wire logic [15:0] tv = timer[cfg[i].tsel]; // R5
    wire logic tc = tChg[cfg[i].tsel];
    wire logic of = ovf[cfg[i].tsel];
    wire logic isCmp = (md >= ETU_CMP0);
    wire logic onePer = (md == ETU_CMP2) || (md == ETU_CMP3); // R12 R13
    assign hit[i] = isCmp && tc && (ccVal[i] == tv); // R9
    assign act[i] = hit[i] && !(onePer && done[i]); // R12 R13
    assign capEv[i] = (rise[i] && (md == ETU_CAP_RISE || md == ETU_CAP_BOTH)) || // R8
                      (fall[i] && (md == ETU_CAP_FALL || md == ETU_CAP_BOTH)); // R8
    wire logic partner;
    wire logic redirect;
    if (i < 8) begin : g_lo
      assign partner = cfg[i].dbl && act[i+8]; // R14
      assign redirect = 1'b0;
    end else begin : g_hi
      assign partner = 1'b0;
      assign redirect = cfg[i-8].dbl; // R14
    end
    wire logic ownTgl = act[i] && !redirect && ((md == ETU_CMP1) || cfg[i].dbl); // R11 R14
    wire logic tgl = ownTgl ^ partner;

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cfg[i] <= '0; // R16
        ccVal[i] <= `ETU_TMR_RST;
        done[i] <= 1'b0;
        drv[i] <= 1'b0;
        pinQ[i] <= 1'b0;
      end else begin
        if (capEv[i]) begin
          ccVal[i] <= tv; // R7
        end else if (wrVal) begin
          ccVal[i] <= merge16(ccVal[i]);
        end
        if (wrCfg[i]) begin
          cfg[i] <= cfgNew;
          drv[i] <= (cfgNew.mode >= ETU_CMP0); // R6
          done[i] <= 1'b0;
        end else begin
          if (act[i] && cfg[i].single) begin
            cfg[i].mode <= ETU_OFF; // R15
          end
          done[i] <= act[i] || (done[i] && !of); // R12 R13
        end
        if (md == ETU_CMP3 && !redirect && act[i]) begin
          pinQ[i] <= 1'b1; // R13
        end else if (md == ETU_CMP3 && !redirect && of) begin
          pinQ[i] <= 1'b0; // R13
        end else if (tgl) begin
          pinQ[i] <= !pinQ[i]; // R11 R14
        end
      end
    end

    assign pinOut[i] = pinQ[i];
    assign pinOe_n[i] = !drv[i]; // R6
  end

  // Interrupt status, write one to clear, set wins
  wire logic wrStat = wrEn && isHit(awaddr, `ETU_OFF_STAT);
  wire logic wrMask = wrEn && isHit(awaddr, `ETU_OFF_MASK);
  wire logic [15:0] clrV = wrStat ? (wdata[15:0] & wMask[15:0]) : 16'h0000;
  wire logic [15:0] setV = act | capEv; // R7 R10 R12
  wire logic [15:0] next_stat = (stat & ~clrV) | setV;
  wire logic [15:0] next_mask = wrMask ? merge16(mask) : mask;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat <= 16'h0000;
      mask <= 16'h0000;
      irq <= 1'b0;
    end else begin
      stat <= next_stat;
      mask <= next_mask;
      irq <= |(next_stat & next_mask);
    end
  end

  // Read selection
  logic [15:0] pinsV;
  logic [31:0] lowRegs [8];
  for (genvar k = 0; k < 16; k++) begin : g_pv
    assign pinsV[k] = pinQ[k];
  end
  assign lowRegs[0] = tctrlWord;
  assign lowRegs[1] = {16'h0000, timer[0]};
  assign lowRegs[2] = {16'h0000, reload[0]};
  assign lowRegs[3] = {16'h0000, timer[1]};
  assign lowRegs[4] = {16'h0000, reload[1]};
  assign lowRegs[5] = {16'h0000, stat};
  assign lowRegs[6] = {16'h0000, mask};
  assign lowRegs[7] = {pinS, pinsV};
  wire logic [3:0] rIdx = araddr[5:2];
  wire logic [31:0] rdMux = !mapped(araddr) ? 32'h0000_0000 :
                            (araddr >= `ETU_OFF_CCC) ? {26'h0, cfg[rIdx]} :
                            (araddr >= `ETU_OFF_CCV) ? {16'h0000, ccVal[rIdx]} :
                            lowRegs[araddr[4:2]];

  // AXI4-Lite handshakes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `ETU_RESP_OK;
    end else if (wrEn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b1;
      bresp <= mapped(awaddr) ? `ETU_RESP_OK : `ETU_RESP_ERR;
    end else begin
      awready <= awvalid && wvalid && !bvalid && !awready;
      wready <= awvalid && wvalid && !bvalid && !awready;
      if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `ETU_RESP_OK;
    end else if (rdHs) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdMux;
      rresp <= mapped(araddr) ? `ETU_RESP_OK : `ETU_RESP_ERR;
    end else begin
      arready <= arvalid && !rvalid && !arready;
      if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_stag;
    (stag && tcfg[0].src == ETU_SRC_PRE && tick[0]) |-> preCnt[2:0] == `ETU_STAG_PH;
  endproperty
  a_stag: assert property (p_stag) else $error("staggered tick off phase"); // R1
  property p_reload;
    (tick[0] && timer[0] == `ETU_TMR_MAX && !g_tmr[0].wrTmr) |=> ovf[0] && timer[0] == $past(reload[0]);
  endproperty
  a_reload: assert property (p_reload) else $error("timer did not reload"); // R2
  property p_six;
    (tcfg[1].run && tcfg[1].src == ETU_SRC_SIX && timerSixOvf && !g_tmr[1].wrTmr &&
     !g_tmr[1].wrap) |=> timer[1] == $past(timer[1]) + `ETU_TMR_INC;
  endproperty
  a_six: assert property (p_six) else $error("timer six clock lost"); // R3
  property p_ext;
    (tcfg[0].run && tcfg[0].src == ETU_SRC_EXT && extRise[0] && !g_tmr[0].wrTmr &&
     !g_tmr[0].wrap) |=> timer[0] == $past(timer[0]) + `ETU_TMR_INC;
  endproperty
  a_ext: assert property (p_ext) else $error("external count lost"); // R4
  property p_cap;
    capEv[1] |=> ccVal[1] == $past(g_ch[1].tv) && stat[1];
  endproperty
  a_cap: assert property (p_cap) else $error("capture failed"); // R7
  property p_fall;
    (cfg[1].mode == ETU_CAP_RISE && fall[1]) |-> !capEv[1];
  endproperty
  a_fall: assert property (p_fall) else $error("wrong capture edge"); // R8
  property p_m0;
    (cfg[5].mode == ETU_CMP0 && act[5] && !wrCfg[5]) |=> $stable(pinOut[5]) && stat[5];
  endproperty
  a_m0: assert property (p_m0) else $error("mode 0 touched pin"); // R10
  property p_m1;
    (cfg[4].mode == ETU_CMP1 && !cfg[4].dbl && act[4]) |=> pinOut[4] != $past(pinOut[4]);
  endproperty
  a_m1: assert property (p_m1) else $error("mode 1 no toggle"); // R11
  property p_m2;
    (cfg[6].mode == ETU_CMP2 && done[6] && !ovf[cfg[6].tsel]) |-> !act[6];
  endproperty
  a_m2: assert property (p_m2) else $error("second mode 2 event"); // R12
  property p_m3;
    (cfg[7].mode == ETU_CMP3 && ovf[cfg[7].tsel] && !act[7]) |=> !pinOut[7];
  endproperty
  a_m3: assert property (p_m3) else $error("mode 3 pin not cleared"); // R13
  property p_single;
    (act[8] && cfg[8].single && !wrCfg[8]) |=> cfg[8].mode == ETU_OFF ##1 !act[8];
  endproperty
  a_single: assert property (p_single) else $error("single event repeated"); // R15
  property p_off;
    (cfg[0].mode == ETU_OFF) |-> !act[0] && !capEv[0];
  endproperty
  a_off: assert property (p_off) else $error("disabled channel active"); // R16
  property p_irq;
    (stat & mask) != 16'h0000 |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  c_cap: cover property (capEv[1] ##1 stat[1]);
  c_m3: cover property (cfg[7].mode == ETU_CMP3 && act[7] ##[1:20] !pinOut[7]);
  c_dbl: cover property (cfg[1].dbl && act[9]);
  c_wr: cover property (wrEn ##1 bvalid);

endmodule : etu_event_timing_unit

//--- verif/etu_pin_model.sv
module etu_pin_model (
  // Design side
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOe_n,
  // Outside event sources
  input wire logic [15:0] drive,
  // Pin levels seen by the design
  output logic [15:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // Driven pin reads back its own level, else the outside source
  assign pinIn = (pinOut & ~pinOe_n) | (drive & pinOe_n);
endmodule : etu_pin_model

//--- verif/etu_event_timing_unit_tb.sv
`include "etu_defines.svh"
module etu_event_timing_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, mm;
  logic [15:0] pinIn, pinOut, pinOe_n, v1, v2, w;
  logic [15:0] drive = 16'h0;
  logic [1:0] extCount = 2'h0;
  logic timerSixOvf = 1'b0;
  int fails = 0, tests_run = 0, cycles = 0;
  logic [31:0] rq[$], mq[$];
  logic [1:0] rrq[$], brq[$];
  localparam logic [7:0] TMR1 = `ETU_OFF_TMR0 + `ETU_TMR_STEP;
  localparam logic [7:0] REL1 = `ETU_OFF_REL0 + `ETU_TMR_STEP;

  always #50 clk = ~clk;

  etu_event_timing_unit DUT (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n), .extCount(extCount),
    .timerSixOvf(timerSixOvf), .irq(irq));

  etu_pin_model PINS (.pinOut(pinOut), .pinOe_n(pinOe_n), .drive(drive), .pinIn(pinIn));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Write with address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = `ETU_RESP_OK);
    brq.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Read; expected word and mask go to the queue for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                    input logic [1:0] er = `ETU_RESP_OK);
    rq.push_back(e);
    mq.push_back(m);
    rrq.push_back(er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  // Result monitor and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rvalid && rready) begin
      mm = mq.pop_front();
      check("rdata", rq.pop_front() & mm, rdata & mm);
      check("rresp", rrq.pop_front(), rresp);
    end
    if (bvalid && bready) begin
      check("bresp", brq.pop_front(), bresp);
    end
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(32'h5ec0));
    v1 = 16'($urandom());
    v2 = 16'($urandom());
    w = 16'($urandom());
    tick(3);
    rst_n <= 1'b1;
    tick(1);
    check("oe", 16'hffff, pinOe_n);
    rd(`ETU_OFF_STAT, 32'h0);
    rd(`ETU_OFF_PINS, 32'h0, 32'hffff);
    rd(`ETU_OFF_END, 32'h0, '1, `ETU_RESP_ERR);
    wr(`ETU_OFF_END, 32'h1, `ETU_RESP_ERR);
    // Capture edges; channel 0 left off
    wr(`ETU_OFF_CCC + 8'h04, 32'h01);
    wr(`ETU_OFF_CCC + 8'h08, 32'h02);
    wr(`ETU_OFF_CCC + 8'h0c, 32'h0b);
    wr(`ETU_OFF_TMR0, {16'h0, v1});
    wr(TMR1, {16'h0, w});
    drive <= 16'h000f;
    tick(6);
    wr(`ETU_OFF_TMR0, {16'h0, v2});
    drive <= 16'h0000;
    tick(6);
    rd(`ETU_OFF_CCV + 8'h04, {16'h0, v1});
    rd(`ETU_OFF_CCV + 8'h08, {16'h0, v2});
    rd(`ETU_OFF_CCV + 8'h0c, {16'h0, w});
    rd(`ETU_OFF_STAT, 32'h0e);
    check("irq", 1'b0, irq);
    wr(`ETU_OFF_STAT, 32'h0e);
    // Timer sources: external count and timer-six overflow with reload
    wr(`ETU_OFF_TMR0, 32'h0);
    wr(TMR1, 32'hfffe);
    wr(REL1, 32'h0100);
    wr(`ETU_OFF_TCTRL, 32'h1121);
    repeat (5) begin
      extCount <= 2'h1;
      tick(3);
      extCount <= 2'h0;
      tick(3);
    end
    repeat (3) begin
      timerSixOvf <= 1'b1;
      tick(1);
      timerSixOvf <= 1'b0;
      tick(3);
    end
    wr(`ETU_OFF_TCTRL, 32'h0);
    rd(`ETU_OFF_TMR0, 32'h5);
    rd(TMR1, 32'h0101);
    // Staggered timer 0 and prescaled timer 1 over 80 edges: ten ticks each
    wr(`ETU_OFF_TMR0, 32'h0);
    wr(TMR1, 32'h0);
    wr(`ETU_OFF_TCTRL, 32'h0001_0701);
    tick(76);
    wr(`ETU_OFF_TCTRL, 32'h0);
    rd(`ETU_OFF_TMR0, 32'ha);
    rd(TMR1, 32'ha);
    // Compare modes 1, 0, 2, 3 on channels 4 to 7
    for (int i = 4; i < 8; i++) begin
      wr(`ETU_OFF_CCV + 8'(4 * i), 32'h1234);
      wr(`ETU_OFF_CCC + 8'(4 * i), (i == 4) ? 32'h5 : (i == 5) ? 32'h4 : 32'(i));
    end
    wr(`ETU_OFF_MASK, 32'h20);
    check("oe4", 1'b0, pinOe_n[4]);
    wr(`ETU_OFF_TMR0, 32'h1234);
    tick(4);
    rd(`ETU_OFF_STAT, 32'hf0);
    rd(`ETU_OFF_PINS, 32'h90, 32'hf0);
    check("pinOut", 32'h90, {16'h0, pinOut & 16'h00f0});
    check("irq", 1'b1, irq);
    wr(`ETU_OFF_STAT, 32'hf0);
    tick(2);
    check("irq", 1'b0, irq);
    wr(`ETU_OFF_TMR0, 32'h1234);
    tick(4);
    rd(`ETU_OFF_STAT, 32'h30);
    rd(`ETU_OFF_PINS, 32'h80, 32'hf0);
    wr(`ETU_OFF_REL0, 32'h0);
    wr(`ETU_OFF_TMR0, 32'hfffd);
    wr(`ETU_OFF_TCTRL, 32'h01);
    tick(8);
    wr(`ETU_OFF_TCTRL, 32'h0);
    rd(`ETU_OFF_PINS, 32'h0, 32'h80);
    // Single event on channel 8, register pair on channels 1 and 9
    wr(`ETU_OFF_CCV + 8'h20, 32'h2222);
    wr(`ETU_OFF_CCC + 8'h20, 32'h25);
    wr(`ETU_OFF_CCV + 8'h04, 32'h3333);
    wr(`ETU_OFF_CCC + 8'h04, 32'h15);
    wr(`ETU_OFF_CCV + 8'h24, 32'h4444);
    wr(`ETU_OFF_CCC + 8'h24, 32'h05);
    wr(`ETU_OFF_TMR0, 32'h2222);
    tick(4);
    wr(`ETU_OFF_TMR0, 32'h2222);
    tick(4);
    rd(`ETU_OFF_PINS, 32'h100, 32'h100);
    wr(`ETU_OFF_TMR0, 32'h3333);
    tick(4);
    rd(`ETU_OFF_PINS, 32'h002, 32'h202);
    wr(`ETU_OFF_TMR0, 32'h4444);
    tick(4);
    rd(`ETU_OFF_PINS, 32'h000, 32'h202);
    tick(2);
    report_and_stop();
  end
endmodule : etu_event_timing_unit_tb
